// file: src/xtpg_pkg.sv
// Package: register map, field positions, reset values and pattern constants
package xtpg_pkg;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_XS2 = 8'h04;
	localparam logic [7:0] A_BYP = 8'h08;
	localparam logic [7:0] A_LANE0 = 8'h0c;
	localparam logic [7:0] A_LANE_STEP = 8'h04;
	localparam logic [7:0] A_FCFG = 8'h1c;
	localparam logic [7:0] A_FCHK = 8'h20;
	localparam logic [7:0] A_FSTAT = 8'h24;
	localparam logic [7:0] A_FLO = 8'h28;
	localparam logic [7:0] A_FHI = 8'h2c;
	localparam logic [7:0] A_ISTAT = 8'h30;
	localparam logic [7:0] A_IMASK = 8'h34;
	localparam logic [7:0] A_SRST = 8'h38;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int SEL_LSB = 0;
	localparam int RUN_BIT = 2;
	localparam int LF_BIT = 10;
	localparam int BYP_BIT = 0;
	localparam int CJ_CHK_BIT = 0;
	localparam int CR_BIT = 1;
	localparam int LOCK_BIT = 15;
	localparam int SRST_BIT = 0;
	localparam int IRQ_LOCK = 0;
	localparam int IRQ_LANE = 1;
	localparam int IRQ_FRAME = 2;
	localparam int IRQ_LF = 3;
	localparam int HALF_W = 16;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [2:0] CTRL_RST = 3'h0;
	localparam logic [1:0] FCFG_RST = 2'h0;
	localparam logic [1:0] FCHK_RST = 2'h0;
	localparam logic [3:0] IRQ_RST = 4'h0;
	localparam logic LF_RST = 1'b1;

	// ----------------------------------------------------------------
	// Pattern selections and words
	// ----------------------------------------------------------------
	localparam logic [1:0] SEL_HIGH = 2'h0;
	localparam logic [1:0] SEL_LOW = 2'h1;
	localparam logic [1:0] SEL_MIX = 2'h2;
	localparam logic [9:0] W_HIGH = 10'h2aa;
	localparam logic [9:0] W_LOW = 10'h3e0;
	localparam logic [9:0] W_MIX_A = 10'h3eb;
	localparam logic [9:0] W_MIX_B = 10'h014;
	localparam logic [39:0] W_SFD = 40'hfb555555d5;
	localparam logic [39:0] W_IDLE = 40'h0707070707;
	localparam logic [15:0] LFSR_SEED = 16'hace1;
	localparam logic [7:0] PAY_WORDS = 8'h40;
	localparam logic [7:0] GAP_WORDS = 8'h0c;
	localparam int FCNT_W = 32;

	typedef enum logic [1:0]
	{
		XTPG_G_IDLE = 2'b00,
		XTPG_G_SFD = 2'b01,
		XTPG_G_PAY = 2'b11,
		XTPG_G_GAP = 2'b10
	} xtpg_gen_t;

	typedef enum logic
	{
		XTPG_C_HUNT = 1'b0,
		XTPG_C_CMP = 1'b1
	} xtpg_chk_t;

	// Random sequence step, shared by sender and checker
	function automatic logic [15:0] xtpg_lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	// Spread one sequence value over the four lanes
	function automatic logic [39:0] xtpg_payload(input logic [15:0] s);
		return {s, s, s[7:0]};
	endfunction

endpackage

// file: src/xtpg_sat_cnt.sv
// Saturating event counter with clear on read
module xtpg_sat_cnt
#(
	parameter int W = 16
)
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic clr,
	input wire logic rd_clr,
	input wire logic inc,
	output logic [W-1:0] cnt
);

	logic [W-1:0] cnt_r;
	logic [W-1:0] cnt_nxt;

	// ----------------------------------------------------------------
	// Count
	// ----------------------------------------------------------------
	// An event in the reading cycle restarts the count at one, so it is not lost
	always_comb
	begin
		cnt_nxt = cnt_r;
		if (clr)
			cnt_nxt = '0;
		else if (rd_clr)
			cnt_nxt = inc ? W'(1) : '0;
		else if (inc && !(&cnt_r))
			cnt_nxt = cnt_r + W'(1);
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
			cnt_r <= '0;
		else
			cnt_r <= cnt_nxt;
	end

	assign cnt = cnt_r;

endmodule

// file: src/xtpg_top.sv
// XAUI jitter test pattern generator and checker with AHB-Lite registers
// ----------------------------------------------------------------
// Functional notes
// - Select field 00 high, 01 low, 10 mixed frequency lane pattern.
// - Run bit starts lane pattern sending and receive checking together.
// - Lane checking continues until software clears the run bit.
// - Each of four lanes counts its own pattern mismatches.
// - Reading a lane counter clears it and leaves the test running.
// - Local fault is latched, clears on read; read twice before testing.
// - Align bypass bit skips receive lane deskew for lane pattern tests.
// - Random frame enable sends the random pattern as packets.
// - Random check enable turns on the receive frame checker.
// - Frame checker sets lock on finding the start word and compares only after it.
// - Frame count spans two registers, clears on read; read before start.
// - Only the first frame count read after a test is valid.
// - Jitter frame check bit enables the same frame checker.
// ----------------------------------------------------------------
//
// The address map and the AHB-Lite interface to the registers were chosen for this implementation.
module xtpg_top
#(
	parameter int LCNT_W = 16
)
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	output logic [39:0] serial_lane_transmit,
	input wire logic [39:0] serial_lane_receive,
	input wire logic rx_local_fault,
	output logic lane_deskew_bypass,
	output logic irq
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic acc, rd_acc, wr, srst;
	logic ap_v_r, ap_v_nxt, ap_wr_r, ap_wr_nxt;
	logic [7:0] ap_addr_r, ap_addr_nxt;
	logic [31:0] rd, hrdata_r, hrdata_nxt;
	logic [3:0] rd_lane, lane_err, w1c;
	logic rd_lf, rd_flo, lane_ok, fchk_on, frame_err, lock_set;
	logic [2:0] ctrl_r, ctrl_nxt;
	logic byp_r, byp_nxt, lf_r, lf_nxt, irq_r, irq_nxt;
	logic [1:0] fcfg_r, fcfg_nxt, fchk_r, fchk_nxt;
	logic [3:0] stat_r, stat_nxt, mask_r, mask_nxt;
	logic [15:0] fhi_r, fhi_nxt;
	xtpg_pkg::xtpg_gen_t gen_st_r, gen_st_nxt;
	logic [7:0] gen_cnt_r, gen_cnt_nxt;
	logic [15:0] gen_lfsr_r, gen_lfsr_nxt;
	logic mix_ph_r, mix_ph_nxt;
	logic [39:0] tx_r, tx_nxt;
	xtpg_pkg::xtpg_chk_t chk_st_r, chk_st_nxt;
	logic [7:0] chk_cnt_r, chk_cnt_nxt;
	logic [15:0] chk_lfsr_r, chk_lfsr_nxt;
	logic lock_r, lock_nxt;
	logic [LCNT_W-1:0] lcnt [4];
	logic [xtpg_pkg::FCNT_W-1:0] fcnt;

	// Lane word for a selection; ph picks the half of the mixed pair
	function automatic logic [9:0] pat_word(input logic [1:0] sel, input logic ph);
		unique case (sel)
			xtpg_pkg::SEL_LOW: return xtpg_pkg::W_LOW;
			xtpg_pkg::SEL_MIX: return ph ? xtpg_pkg::W_MIX_B : xtpg_pkg::W_MIX_A;
			default: return xtpg_pkg::W_HIGH;
		endcase
	endfunction

	// Mixed lanes may arrive in either phase, so either half is accepted
	function automatic logic lane_match(input logic [9:0] w, input logic [1:0] sel);
		if (sel == xtpg_pkg::SEL_MIX)
			return (w == pat_word(sel, 1'b0)) || (w == pat_word(sel, 1'b1));
		return w == pat_word(sel, 1'b0);
	endfunction

	// ----------------------------------------------------------------
	// AHB-Lite slave: zero wait, read data and read effects at address phase
	// ----------------------------------------------------------------
	// Reads are decoded in the address phase so hrdata leaves a flop
	always_comb
	begin
		acc = hsel && hready && htrans[1];
		rd_acc = acc && !hwrite;
		ap_v_nxt = acc;
		ap_wr_nxt = hwrite;
		ap_addr_nxt = haddr[7:0];
		rd = '0;
		rd_lane = '0;
		rd_lf = 1'b0;
		rd_flo = 1'b0;
		for (int i = 0; i < 4; i++)
		begin
			if (haddr[7:0] == xtpg_pkg::A_LANE0 + 8'(i) * xtpg_pkg::A_LANE_STEP)
			begin
				rd[LCNT_W-1:0] = lcnt[i];
				rd_lane[i] = rd_acc;
			end
		end
		case (haddr[7:0])
			xtpg_pkg::A_CTRL: rd[2:0] = ctrl_r;
			xtpg_pkg::A_XS2:
			begin
				rd[xtpg_pkg::LF_BIT] = lf_r;
				rd_lf = rd_acc;
			end
			xtpg_pkg::A_BYP: rd[xtpg_pkg::BYP_BIT] = byp_r;
			xtpg_pkg::A_FCFG: rd[1:0] = fcfg_r;
			xtpg_pkg::A_FCHK: rd[1:0] = fchk_r;
			xtpg_pkg::A_FSTAT: rd[xtpg_pkg::LOCK_BIT] = lock_r;
			xtpg_pkg::A_FLO:
			begin
				rd[xtpg_pkg::HALF_W-1:0] = fcnt[xtpg_pkg::HALF_W-1:0];
				rd_flo = rd_acc;
			end
			xtpg_pkg::A_FHI: rd[xtpg_pkg::HALF_W-1:0] = fhi_r;
			xtpg_pkg::A_ISTAT: rd[3:0] = stat_r;
			xtpg_pkg::A_IMASK: rd[3:0] = mask_r;
			default: ;
		endcase
		hrdata_nxt = rd_acc ? rd : '0;
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			ap_v_r <= 1'b0;
			ap_wr_r <= 1'b0;
			ap_addr_r <= '0;
			hrdata_r <= '0;
		end
		else
		begin
			ap_v_r <= ap_v_nxt;
			ap_wr_r <= ap_wr_nxt;
			ap_addr_r <= ap_addr_nxt;
			hrdata_r <= hrdata_nxt;
		end
	end

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_r;

	// ----------------------------------------------------------------
	// Control, status and interrupt registers
	// ----------------------------------------------------------------
	// Writes land in the data phase; hardware sets win over clears
	always_comb
	begin
		wr = ap_v_r && ap_wr_r;
		srst = wr && (ap_addr_r == xtpg_pkg::A_SRST) && hwdata[xtpg_pkg::SRST_BIT];
		ctrl_nxt = ctrl_r;
		byp_nxt = byp_r;
		fcfg_nxt = fcfg_r;
		fchk_nxt = fchk_r;
		mask_nxt = mask_r;
		w1c = '0;
		if (wr)
		begin
			case (ap_addr_r)
				xtpg_pkg::A_CTRL: ctrl_nxt = hwdata[2:0];
				xtpg_pkg::A_BYP: byp_nxt = hwdata[xtpg_pkg::BYP_BIT];
				xtpg_pkg::A_FCFG: fcfg_nxt = hwdata[1:0];
				xtpg_pkg::A_FCHK: fchk_nxt = hwdata[1:0];
				xtpg_pkg::A_IMASK: mask_nxt = hwdata[3:0];
				xtpg_pkg::A_ISTAT: w1c = hwdata[3:0];
				default: ;
			endcase
		end
		lf_nxt = rx_local_fault || (lf_r && !rd_lf);
		stat_nxt = stat_r & ~w1c;
		stat_nxt[xtpg_pkg::IRQ_LOCK] = stat_nxt[xtpg_pkg::IRQ_LOCK] | lock_set;
		stat_nxt[xtpg_pkg::IRQ_LANE] = stat_nxt[xtpg_pkg::IRQ_LANE] | (|lane_err);
		stat_nxt[xtpg_pkg::IRQ_FRAME] = stat_nxt[xtpg_pkg::IRQ_FRAME] | frame_err;
		stat_nxt[xtpg_pkg::IRQ_LF] = stat_nxt[xtpg_pkg::IRQ_LF] | rx_local_fault;
		fhi_nxt = rd_flo ? fcnt[xtpg_pkg::FCNT_W-1:xtpg_pkg::HALF_W] : fhi_r;
		irq_nxt = |(stat_r & mask_r);
		// Soft reset returns all but the bus pipeline and irq to reset state; irq clears a cycle later
		if (srst)
		begin
			ctrl_nxt = xtpg_pkg::CTRL_RST;
			byp_nxt = 1'b0;
			fcfg_nxt = xtpg_pkg::FCFG_RST;
			fchk_nxt = xtpg_pkg::FCHK_RST;
			mask_nxt = xtpg_pkg::IRQ_RST;
			stat_nxt = xtpg_pkg::IRQ_RST;
			lf_nxt = xtpg_pkg::LF_RST;
			fhi_nxt = '0;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			ctrl_r <= xtpg_pkg::CTRL_RST;
			byp_r <= 1'b0;
			fcfg_r <= xtpg_pkg::FCFG_RST;
			fchk_r <= xtpg_pkg::FCHK_RST;
			mask_r <= xtpg_pkg::IRQ_RST;
			stat_r <= xtpg_pkg::IRQ_RST;
			lf_r <= xtpg_pkg::LF_RST;
			fhi_r <= '0;
			irq_r <= 1'b0;
		end
		else
		begin
			ctrl_r <= ctrl_nxt;
			byp_r <= byp_nxt;
			fcfg_r <= fcfg_nxt;
			fchk_r <= fchk_nxt;
			mask_r <= mask_nxt;
			stat_r <= stat_nxt;
			lf_r <= lf_nxt;
			fhi_r <= fhi_nxt;
			irq_r <= irq_nxt;
		end
	end

	assign irq = irq_r;
	assign lane_deskew_bypass = byp_r;

	// ----------------------------------------------------------------
	// Transmit pattern generator
	// ----------------------------------------------------------------
	// Lane patterns take priority; select 11 names no pattern, so idle or frames are sent
	always_comb
	begin
		lane_ok = ctrl_r[xtpg_pkg::RUN_BIT] && (ctrl_r[1:0] != 2'h3);
		gen_st_nxt = gen_st_r;
		gen_cnt_nxt = gen_cnt_r;
		gen_lfsr_nxt = gen_lfsr_r;
		mix_ph_nxt = 1'b0;
		tx_nxt = xtpg_pkg::W_IDLE;
		if (lane_ok)
		begin
			tx_nxt = {4{pat_word(ctrl_r[1:0], mix_ph_r)}};
			mix_ph_nxt = !mix_ph_r;
			gen_st_nxt = xtpg_pkg::XTPG_G_IDLE;
		end
		else if (!fcfg_r[xtpg_pkg::CR_BIT])
			gen_st_nxt = xtpg_pkg::XTPG_G_IDLE;
		else
		begin
			unique case (gen_st_r)
				xtpg_pkg::XTPG_G_IDLE: gen_st_nxt = xtpg_pkg::XTPG_G_SFD;
				xtpg_pkg::XTPG_G_SFD:
				begin
					tx_nxt = xtpg_pkg::W_SFD;
					gen_st_nxt = xtpg_pkg::XTPG_G_PAY;
					gen_cnt_nxt = '0;
					gen_lfsr_nxt = xtpg_pkg::LFSR_SEED;
				end
				xtpg_pkg::XTPG_G_PAY:
				begin
					tx_nxt = xtpg_pkg::xtpg_payload(gen_lfsr_r);
					gen_lfsr_nxt = xtpg_pkg::xtpg_lfsr(gen_lfsr_r);
					gen_cnt_nxt = gen_cnt_r + 8'h01;
					if (gen_cnt_r == xtpg_pkg::PAY_WORDS - 8'h01)
					begin
						gen_st_nxt = xtpg_pkg::XTPG_G_GAP;
						gen_cnt_nxt = '0;
					end
				end
				xtpg_pkg::XTPG_G_GAP:
				begin
					gen_cnt_nxt = gen_cnt_r + 8'h01;
					if (gen_cnt_r == xtpg_pkg::GAP_WORDS - 8'h01)
						gen_st_nxt = xtpg_pkg::XTPG_G_SFD;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n || srst)
		begin
			gen_st_r <= xtpg_pkg::XTPG_G_IDLE;
			gen_cnt_r <= '0;
			gen_lfsr_r <= xtpg_pkg::LFSR_SEED;
			mix_ph_r <= 1'b0;
			tx_r <= xtpg_pkg::W_IDLE;
		end
		else
		begin
			gen_st_r <= gen_st_nxt;
			gen_cnt_r <= gen_cnt_nxt;
			gen_lfsr_r <= gen_lfsr_nxt;
			mix_ph_r <= mix_ph_nxt;
			tx_r <= tx_nxt;
		end
	end

	assign serial_lane_transmit = tx_r;

	// ----------------------------------------------------------------
	// Receive checkers
	// ----------------------------------------------------------------
	// Frame checker hunts for the start word, so link latency needs no tuning
	always_comb
	begin
		lane_err = '0;
		for (int i = 0; i < 4; i++)
		begin
			if (lane_ok && !lane_match(serial_lane_receive[10*i +: 10], ctrl_r[1:0]))
				lane_err[i] = 1'b1;
		end
		fchk_on = fchk_r[xtpg_pkg::CR_BIT] || fchk_r[xtpg_pkg::CJ_CHK_BIT];
		chk_st_nxt = chk_st_r;
		chk_cnt_nxt = chk_cnt_r;
		chk_lfsr_nxt = chk_lfsr_r;
		frame_err = 1'b0;
		unique case (chk_st_r)
			xtpg_pkg::XTPG_C_HUNT:
			begin
				if (fchk_on && serial_lane_receive == xtpg_pkg::W_SFD)
				begin
					chk_st_nxt = xtpg_pkg::XTPG_C_CMP;
					chk_cnt_nxt = '0;
					chk_lfsr_nxt = xtpg_pkg::LFSR_SEED;
				end
			end
			xtpg_pkg::XTPG_C_CMP:
			begin
				frame_err = serial_lane_receive != xtpg_pkg::xtpg_payload(chk_lfsr_r);
				chk_lfsr_nxt = xtpg_pkg::xtpg_lfsr(chk_lfsr_r);
				chk_cnt_nxt = chk_cnt_r + 8'h01;
				if (chk_cnt_r == xtpg_pkg::PAY_WORDS - 8'h01)
					chk_st_nxt = xtpg_pkg::XTPG_C_HUNT;
			end
		endcase
		if (!fchk_on)
			chk_st_nxt = xtpg_pkg::XTPG_C_HUNT;
		lock_nxt = fchk_on && (lock_r || chk_st_nxt == xtpg_pkg::XTPG_C_CMP);
		lock_set = lock_nxt && !lock_r;
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n || srst)
		begin
			chk_st_r <= xtpg_pkg::XTPG_C_HUNT;
			chk_cnt_r <= '0;
			chk_lfsr_r <= xtpg_pkg::LFSR_SEED;
			lock_r <= 1'b0;
		end
		else
		begin
			chk_st_r <= chk_st_nxt;
			chk_cnt_r <= chk_cnt_nxt;
			chk_lfsr_r <= chk_lfsr_nxt;
			lock_r <= lock_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Error counters
	// ----------------------------------------------------------------
	for (genvar g = 0; g < 4; g++)
	begin : g_lane
		xtpg_sat_cnt #(.W(LCNT_W)) u_lane_cnt
		(
			.sys_clk(sys_clk),
			.rst_n(rst_n),
			.clr(srst),
			.rd_clr(rd_lane[g]),
			.inc(lane_err[g]),
			.cnt(lcnt[g])
		);
	end

	// Whole count clears on the low read; the high half is held until the next low read
	xtpg_sat_cnt #(.W(xtpg_pkg::FCNT_W)) u_frame_cnt
	(
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.clr(srst),
		.rd_clr(rd_flo),
		.inc(frame_err),
		.cnt(fcnt)
	);

endmodule

// file: tb/xtpg_loop.sv
// Far side model: serial loop from transmit lanes back to receive lanes
module xtpg_loop
(
	input wire logic sys_clk,
	input wire logic [39:0] tx,
	input wire logic [3:0] err_lanes,
	output logic [39:0] rx
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [39:0] flip;
	// Bit 0 of a lane flips so that no pattern word turns into another valid one
	assign flip = {9'h0, err_lanes[3], 9'h0, err_lanes[2], 9'h0, err_lanes[1], 9'h0, err_lanes[0]};
	initial rx = 40'h0;
	// One cycle of line delay
	always @(posedge sys_clk)
		rx <= tx ^ flip;
endmodule

// file: tb/xtpg_top_properties.sv
// Port-level assertions for the pattern block
module xtpg_checker
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	input wire logic [39:0] serial_lane_transmit,
	input wire logic lane_deskew_bypass,
	input wire logic irq
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	logic [39:0] tx;
	assign tx = serial_lane_transmit;
	// ----------------------------------------------------------------
	// Bus steps
	// ----------------------------------------------------------------
	sequence s_wr(logic [7:0] a);
		hsel && hready && htrans[1] && hwrite && haddr[7:0] == a;
	endsequence
	sequence s_run(logic [1:0] sel);
		s_wr(xtpg_pkg::A_CTRL) ##1 (hwdata[2:0] == {1'b1, sel});
	endsequence
	sequence s_frame_on;
		s_wr(xtpg_pkg::A_FCFG) ##1 hwdata[1];
	endsequence
	chk_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus not ready or not okay");
	chk_rdata_idle: assert property (!$past(hsel && hready && htrans[1] && !hwrite)
		|-> hrdata == 32'h0)
		else $error("read data outside data phase");
	chk_reset_idle: assert property ($rose(rst_n) |-> tx == xtpg_pkg::W_IDLE && !irq)
		else $error("outputs not idle after reset");
	chk_bypass_pin: assert property (s_wr(xtpg_pkg::A_BYP) |=> ##1
		lane_deskew_bypass == $past(hwdata[0]))
		else $error("bypass pin does not follow register");
	chk_high_pattern: assert property (s_run(xtpg_pkg::SEL_HIGH) |=> ##1
		tx == {4{xtpg_pkg::W_HIGH}})
		else $error("high pattern not sent");
	chk_low_pattern: assert property (s_run(xtpg_pkg::SEL_LOW) |=> ##1
		tx == {4{xtpg_pkg::W_LOW}})
		else $error("low pattern not sent");
	chk_mixed_pattern: assert property (s_run(xtpg_pkg::SEL_MIX) |=> ##1
		tx == {4{tx[9:0]}} && (tx[9:0] == xtpg_pkg::W_MIX_A || tx[9:0] == xtpg_pkg::W_MIX_B))
		else $error("mixed pattern not sent");
	chk_frame_start: assert property (s_frame_on |=> ##[0:2] tx == xtpg_pkg::W_SFD)
		else $error("frame start word missing");
	// A frame is start word, 64 payload words, then 12 idle words
	chk_frame_length: assert property (tx == xtpg_pkg::W_SFD |-> ##65
		tx == xtpg_pkg::W_IDLE ##12 (tx == xtpg_pkg::W_SFD || tx == xtpg_pkg::W_IDLE))
		else $error("frame length wrong");
endmodule

// file: tb/xtpg_top_tb_top.sv
// Self-checking bench for the pattern block
module xtpg_top_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int CW = 4;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic hreadyout;
	logic hresp;
	logic [31:0] hrdata;
	logic [39:0] tx;
	logic [39:0] rx;
	logic fault = 1'b0;
	logic bypass;
	logic irq;
	logic [3:0] err_lanes = 4'h0;
	logic [31:0] rd;
	int n_mismatch = 0;
	int check_count = 0;
	int cyc = 0;
	always #4 sys_clk = ~sys_clk;
	// Small counter width so saturation is reached quickly
	xtpg_top #(.LCNT_W(CW)) DUT (.sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .serial_lane_transmit(tx),
		.serial_lane_receive(rx), .rx_local_fault(fault), .lane_deskew_bypass(bypass), .irq(irq));
	xtpg_loop LOOP (.sys_clk(sys_clk), .tx(tx), .err_lanes(err_lanes), .rx(rx));
	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic results();
		if (n_mismatch == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Hang guard: the whole sequence needs under a thousand cycles
	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			n_mismatch++;
			results();
		end
	end
	// One single AHB transfer; read data lands in rd
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= wr;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
		bus(1'b0, a, 32'h0);
		check(what, {8'h0, rd}, {8'h0, exp});
	endtask
	function automatic logic [7:0] lane(input int i);
		return 8'(xtpg_pkg::A_LANE0 + xtpg_pkg::A_LANE_STEP * i);
	endfunction
	// Corrupt the chosen lanes for exactly n received words
	task automatic inject(input logic [3:0] m, input int n);
		@(posedge sys_clk);
		err_lanes <= m;
		repeat (n) @(posedge sys_clk);
		err_lanes <= 4'h0;
		repeat (4) @(posedge sys_clk);
	endtask
	task automatic sreset();
		bus(1'b1, xtpg_pkg::A_SRST, 32'h1);
		repeat (2) @(posedge sys_clk);
		rdc(xtpg_pkg::A_XS2, 32'h400, "fault first read");
		rdc(xtpg_pkg::A_XS2, 32'h0, "fault second read");
	endtask
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_start();
		check("idle lanes", tx, xtpg_pkg::W_IDLE);
		rdc(xtpg_pkg::A_XS2, 32'h400, "fault after reset");
		rdc(xtpg_pkg::A_XS2, 32'h0, "fault cleared");
		@(posedge sys_clk);
		fault <= 1'b1;
		@(posedge sys_clk);
		fault <= 1'b0;
		rdc(xtpg_pkg::A_XS2, 32'h400, "fault latched");
		check("masked irq", {39'h0, irq}, 40'h0);
		rdc(xtpg_pkg::A_ISTAT, 32'h8, "fault status");
		bus(1'b1, xtpg_pkg::A_IMASK, 32'h8);
		repeat (2) @(posedge sys_clk);
		check("fault irq", {39'h0, irq}, 40'h1);
		rdc(8'h3c, 32'h0, "unmapped read");
	endtask
	task automatic t_lane(input logic [1:0] sel, input logic [9:0] wa, input logic [9:0] wb);
		logic [9:0] w;
		sreset();
		bus(1'b1, xtpg_pkg::A_BYP, 32'h1);
		@(posedge sys_clk);
		check("bypass pin", {39'h0, bypass}, 40'h1);
		bus(1'b1, xtpg_pkg::A_CTRL, {29'h0, 1'b1, sel});
		repeat (4) @(posedge sys_clk);
		w = tx[9:0];
		check("lane words", tx, {4{(w === wb) ? wb : wa}});
		for (int i = 0; i < 4; i++)
			bus(1'b0, lane(i), 32'h0);
		inject(4'h2, 3);
		rdc(lane(1), 32'h3, "lane1 count");
		rdc(lane(0), 32'h0, "lane0 count");
		rdc(lane(1), 32'h0, "lane1 cleared");
		inject(4'h8, 20);
		rdc(lane(3), 32'((1 << CW) - 1), "lane3 saturated");
		w = tx[9:0];
		check("lanes still sent", tx, {4{(w === wb) ? wb : wa}});
		bus(1'b1, xtpg_pkg::A_CTRL, {30'h0, sel});
		inject(4'h1, 3);
		rdc(lane(0), 32'h0, "lane0 after stop");
		rdc(xtpg_pkg::A_ISTAT, 32'h2, "lane status");
	endtask
	task automatic t_frame(input logic [1:0] chk);
		sreset();
		bus(1'b0, xtpg_pkg::A_FLO, 32'h0);
		bus(1'b0, xtpg_pkg::A_FHI, 32'h0);
		bus(1'b1, xtpg_pkg::A_FCFG, 32'h2);
		rdc(xtpg_pkg::A_FSTAT, 32'h0, "lock before check");
		bus(1'b1, xtpg_pkg::A_IMASK, 32'h4);
		bus(1'b1, xtpg_pkg::A_FCHK, {30'h0, chk});
		do @(posedge sys_clk); while (tx !== xtpg_pkg::W_SFD);
		repeat (4) @(posedge sys_clk);
		inject(4'h1, 2);
		repeat (80) @(posedge sys_clk);
		rdc(xtpg_pkg::A_FSTAT, 32'h8000, "frame lock");
		check("frame irq", {39'h0, irq}, 40'h1);
		rdc(xtpg_pkg::A_FLO, 32'h2, "frame count low");
		rdc(xtpg_pkg::A_FHI, 32'h0, "frame count high");
		rdc(xtpg_pkg::A_ISTAT, 32'h5, "frame status");
		bus(1'b1, xtpg_pkg::A_ISTAT, 32'h4);
		repeat (2) @(posedge sys_clk);
		check("irq cleared", {39'h0, irq}, 40'h0);
		bus(1'b1, xtpg_pkg::A_SRST, 32'h1);
		repeat (80) @(posedge sys_clk);
	endtask
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		repeat (12) @(posedge sys_clk);
		rst_n <= 1'b1;
		t_start();
		t_lane(xtpg_pkg::SEL_HIGH, xtpg_pkg::W_HIGH, xtpg_pkg::W_HIGH);
		t_lane(xtpg_pkg::SEL_LOW, xtpg_pkg::W_LOW, xtpg_pkg::W_LOW);
		t_lane(xtpg_pkg::SEL_MIX, xtpg_pkg::W_MIX_A, xtpg_pkg::W_MIX_B);
		t_frame(2'h2);
		t_frame(2'h1);
		results();
	end
endmodule

bind xtpg_top xtpg_checker CHK (.sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
	.hresp(hresp), .hrdata(hrdata), .serial_lane_transmit(serial_lane_transmit),
	.lane_deskew_bypass(lane_deskew_bypass), .irq(irq));
